// file: usb_flag_pkg.sv
// Purpose: Constants and types shared by the USB flag and status logic
// Assumes: 8-bit register port, 40 MHz system clock
// Notes:   Offsets are byte addresses on the plain register port
package usb_flag_pkg;
   localparam int          NUM_EP            = 5;
   localparam int          DATA_W            = 8;
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  IN_NAK_FLAGS_ADDR = 8'hEB;
   localparam logic [7:0]  USB_CTRL_ADDR     = 8'hEC;
   localparam logic [7:0]  OUT_FLAGS_ADDR    = 8'hE8;
   localparam logic [7:0]  IRQ_STATUS_ADDR   = 8'hE9;
   localparam logic [7:0]  IRQ_MASK_ADDR     = 8'hEA;
   localparam logic [7:0]  REG_RESET         = 8'h00;
   localparam int          CTRL_WAKEUP_BIT   = 0;
   localparam int          CTRL_VISIBLE_BIT  = 1;
   localparam int          CTRL_USBEN_BIT    = 2;
   localparam int          IRQ_NAK_BIT       = 0;
   localparam int          IRQ_OUT_BIT       = 1;
   localparam logic [4:0]  EP_NONE           = 5'h00;
   localparam logic [4:0]  ODD_EP_MASK       = 5'h0A;
   typedef logic [NUM_EP-1:0] ep_vec_t;
endpackage : usb_flag_pkg

// file: usb_ep_ready_if.sv
// Purpose: Carries IN FIFO readiness between the top and the ready tracker
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface usb_ep_ready_if;
   import usb_flag_pkg::*;
   ep_vec_t loadStrobe;
   ep_vec_t sizeWrite;
   ep_vec_t sentDone;
   ep_vec_t ready;
   modport owner (output loadStrobe, output sizeWrite, output sentDone, input ready);
   modport tracker (input loadStrobe, input sizeWrite, input sentDone, output ready);
endinterface : usb_ep_ready_if
`default_nettype wire

// file: usb_in_ready.sv
// Purpose: Tracks the ready-to-send state of each IN endpoint FIFO
// Assumes: Events are one-cycle pulses on clk
// Notes:   A completed transfer returns the FIFO to not ready unless a size write arrives in the same cycle
`timescale 1ns/1ps
`default_nettype none
module usb_in_ready (
   input  wire logic      clk,
   input  wire logic      rst_n,
   usb_ep_ready_if.tracker rdy
);
   import usb_flag_pkg::*;

   ep_vec_t loaded;
   ep_vec_t armed;

   // ----------------------------------------
   // Per endpoint state
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : gEp
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               loaded[g] <= 1'b0;
            end else if (rdy.sentDone[g]) begin
               loaded[g] <= 1'b0;
            end else if (rdy.loadStrobe[g]) begin
               loaded[g] <= 1'b1;
            end
         end
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               armed[g] <= 1'b0;
            end else if (rdy.sizeWrite[g]) begin
               armed[g] <= 1'b1;
            end else if (rdy.sentDone[g]) begin
               armed[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Not ready only while neither loaded nor armed
   assign rdy.ready = loaded | armed;

   property p_size_arms;
      @(posedge clk) disable iff (!rst_n)
         rdy.sizeWrite[1] |=> rdy.ready[1];
   endproperty
   a_size_arms: assert property (p_size_arms) else $error("Size write did not arm FIFO");

   property p_idle_not_ready;
      @(posedge clk) disable iff (!rst_n)
         rdy.sentDone[1] && !rdy.sizeWrite[1] |=> !rdy.ready[1];
   endproperty
   a_idle_not_ready: assert property (p_idle_not_ready) else $error("Ready state inconsistent");
endmodule : usb_in_ready
`default_nettype wire

// file: usb_fifo_flag_status.sv
// Purpose: USB endpoint FIFO flags, NAK decision and control register
// Assumes: Register port is synchronous to clk; FIFO status inputs on clk
// Notes:   Interrupt status clears on read
//
// What this block does
// - One IN NAK flag per endpoint 0..4, set when an IN gets NAK.
// - IN FIFO not ready while not loaded and size not written.
// - Writing the transfer size register makes the IN FIFO ready.
// - IN requests to a not-ready FIFO are answered with NAK while the engine enable bit is set.
// - Flags stay set until firmware writes zero to the bit.
// - With paired FIFOs only odd endpoint flags can set.
// - NAK flag register at 0xEB, reset 0x00, bits 7..5 reserved.
// - One OUT FIFO flag per endpoint 0..4, upper bits reserved.
// - After reset the control register reads 0x00, function disabled.
// - Control register holds engine enable, visibility and remote wakeup.
// - OUT flag sets when FIFO goes from empty to full.
// - Visibility bit maps the selected FIFO into external data space.
// - Wakeup bit forces K state; resume flag not set by it.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_flag_status (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [usb_flag_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [usb_flag_pkg::DATA_W-1:0] regWdata,
   input  wire logic                      regWrite,
   input  wire logic                      regRead,
   output logic      [usb_flag_pkg::DATA_W-1:0] regRdata,
   input  wire logic                      fifoPaired,
   input  wire logic                      inToken,
   input  wire logic [2:0]                tokenEp,
   output logic                           sendNak,
   input  wire usb_flag_pkg::ep_vec_t     inLoadStrobe,
   input  wire usb_flag_pkg::ep_vec_t     sizeWrite,
   input  wire usb_flag_pkg::ep_vec_t     inSentDone,
   input  wire usb_flag_pkg::ep_vec_t     outFifoFull,
   output logic                           engineEnable,
   output logic                           fifoVisible,
   output logic                           forceK,
   output logic                           irq
);
   import usb_flag_pkg::*;

   logic    [7:0] ctrlReg;
   ep_vec_t       inNakFlags;
   ep_vec_t       outFlags;
   ep_vec_t       outFullQ;
   logic    [1:0] irqStatus;
   logic    [1:0] irqMask;
   ep_vec_t       nakEvent;
   ep_vec_t       outEvent;
   ep_vec_t       allowMask;
   ep_vec_t       tokenHot;
   logic    [7:0] next_rdata;

   usb_ep_ready_if rdyBus ();

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic ep_vec_t epDecode(input logic [2:0] ep);
      ep_vec_t v;
      v = EP_NONE;
      if (ep < 3'(NUM_EP)) begin
         v[ep] = 1'b1;
      end
      return v;
   endfunction

   function automatic logic isWrite(input logic [7:0] a, input logic [7:0] target,
                                    input logic wr);
      return wr && (a == target);
   endfunction

   // ----------------------------------------
   // Ready tracking
   // ----------------------------------------
   assign rdyBus.loadStrobe = inLoadStrobe;
   assign rdyBus.sizeWrite  = sizeWrite;
   assign rdyBus.sentDone   = inSentDone;

   usb_in_ready uReady (
      .clk   (clk),
      .rst_n (rst_n),
      .rdy   (rdyBus.tracker)
   );

   // ----------------------------------------
   // NAK decision
   // ----------------------------------------
   assign tokenHot = inToken && engineEnable ? epDecode(tokenEp) : EP_NONE;
   assign nakEvent = tokenHot & ~rdyBus.ready;
   assign sendNak  = |nakEvent;

   // Paired FIFOs gate even endpoint flags
   assign allowMask = fifoPaired ? ODD_EP_MASK : {NUM_EP{1'b1}};

   // ----------------------------------------
   // IN NAK flags
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         inNakFlags <= REG_RESET[NUM_EP-1:0];
      end else if (isWrite(regAddr, IN_NAK_FLAGS_ADDR, regWrite)) begin
         // Zero clears, one keeps; a new event wins
         inNakFlags <= (inNakFlags & regWdata[NUM_EP-1:0]) | (nakEvent & allowMask);
      end else begin
         inNakFlags <= inNakFlags | (nakEvent & allowMask);
      end
   end

   // ----------------------------------------
   // OUT FIFO flags
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outFullQ <= EP_NONE;
      end else begin
         outFullQ <= outFifoFull;
      end
   end

   assign outEvent = outFifoFull & ~outFullQ & allowMask;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outFlags <= REG_RESET[NUM_EP-1:0];
      end else if (isWrite(regAddr, OUT_FLAGS_ADDR, regWrite)) begin
         outFlags <= (outFlags & regWdata[NUM_EP-1:0]) | outEvent;
      end else begin
         outFlags <= outFlags | outEvent;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrlReg <= REG_RESET;
      end else if (isWrite(regAddr, USB_CTRL_ADDR, regWrite)) begin
         ctrlReg <= {5'h00, regWdata[2:0]};
      end
   end

   assign engineEnable = ctrlReg[CTRL_USBEN_BIT];
   assign fifoVisible  = ctrlReg[CTRL_VISIBLE_BIT];
   // Wakeup drives K only; no resume event is raised here
   assign forceK       = ctrlReg[CTRL_WAKEUP_BIT];

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqMask <= 2'h0;
      end else if (isWrite(regAddr, IRQ_MASK_ADDR, regWrite)) begin
         irqMask <= regWdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irqStatus <= 2'h0;
      end else begin
         irqStatus[IRQ_NAK_BIT] <= (irqStatus[IRQ_NAK_BIT] && !(regRead && regAddr == IRQ_STATUS_ADDR))
                                   || |(nakEvent & allowMask);
         irqStatus[IRQ_OUT_BIT] <= (irqStatus[IRQ_OUT_BIT] && !(regRead && regAddr == IRQ_STATUS_ADDR))
                                   || |outEvent;
      end
   end

   assign irq = |(irqStatus & irqMask);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      unique case (regAddr)
         IN_NAK_FLAGS_ADDR: next_rdata = {3'h0, inNakFlags};
         OUT_FLAGS_ADDR:    next_rdata = {3'h0, outFlags};
         USB_CTRL_ADDR:     next_rdata = ctrlReg;
         IRQ_STATUS_ADDR:   next_rdata = {6'h00, irqStatus};
         IRQ_MASK_ADDR:     next_rdata = {6'h00, irqMask};
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= next_rdata;
      end else begin
         regRdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_nak_sets_flag;
      @(posedge clk) disable iff (!rst_n)
         (nakEvent[4] && allowMask[4]) |=> inNakFlags[4];
   endproperty
   a_nak_sets_flag: assert property (p_nak_sets_flag) else $error("NAK flag not set");

   property p_not_ready_nak;
      @(posedge clk) disable iff (!rst_n)
         inToken && engineEnable && tokenEp == 3'd2 && !rdyBus.ready[2] |-> sendNak;
   endproperty
   a_not_ready_nak: assert property (p_not_ready_nak) else $error("Missing NAK to not-ready FIFO");

   property p_ready_no_nak;
      @(posedge clk) disable iff (!rst_n)
         inToken && tokenEp == 3'd1 && rdyBus.ready[1] |-> !sendNak;
   endproperty
   a_ready_no_nak: assert property (p_ready_no_nak) else $error("NAK to ready FIFO");

   property p_flag_sticky;
      @(posedge clk) disable iff (!rst_n)
         inNakFlags[1] && !(regWrite && regAddr == IN_NAK_FLAGS_ADDR && !regWdata[1]) |=> inNakFlags[1];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("NAK flag lost without clear");

   property p_clear_works;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == OUT_FLAGS_ADDR && !regWdata[0] && !outEvent[0] |=> !outFlags[0];
   endproperty
   a_clear_works: assert property (p_clear_works) else $error("OUT flag clear failed");

   property p_paired_even;
      @(posedge clk) disable iff (!rst_n)
         fifoPaired && !inNakFlags[2] |=> !inNakFlags[2];
   endproperty
   a_paired_even: assert property (p_paired_even) else $error("Even flag set while paired");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rst_n)
         regRead && (regAddr == IN_NAK_FLAGS_ADDR || regAddr == OUT_FLAGS_ADDR) |=> regRdata[7:5] == 3'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero");

   property p_out_edge;
      @(posedge clk) disable iff (!rst_n)
         outFifoFull[2] && !$past(outFifoFull[2]) && allowMask[2] |=> outFlags[2];
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("OUT flag not set on full");

   property p_reset_ctrl;
      @(posedge clk) $past(!rst_n) |-> ctrlReg == 8'h00 && !engineEnable;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("Control not cleared by reset");

   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == IN_NAK_FLAGS_ADDR && nakEvent[3] && allowMask[3] |=> inNakFlags[3];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Set lost to clear");

   property p_disabled_no_nak;
      @(posedge clk) disable iff (!rst_n)
         !engineEnable |-> !sendNak;
   endproperty
   a_disabled_no_nak: assert property (p_disabled_no_nak) else $error("NAK while disabled");

   property p_ctrl_write;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == USB_CTRL_ADDR |=> ctrlReg[2:0] == $past(regWdata[2:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("Control write lost");

   property p_even_out;
      @(posedge clk) disable iff (!rst_n)
         fifoPaired && !outFlags[4] |=> !outFlags[4];
   endproperty
   a_even_out: assert property (p_even_out) else $error("Even OUT flag set while paired");

   property p_out_needs_edge;
      @(posedge clk) disable iff (!rst_n)
         !outFlags[4] && !(outFifoFull[4] && !outFullQ[4]) |=> !outFlags[4];
   endproperty
   a_out_needs_edge: assert property (p_out_needs_edge) else $error("OUT flag set without fill");

   property p_nak_needs_event;
      @(posedge clk) disable iff (!rst_n)
         !inNakFlags[1] && !nakEvent[1] |=> !inNakFlags[1];
   endproperty
   a_nak_needs_event: assert property (p_nak_needs_event) else $error("NAK flag set without NAK");

   property p_wakeup_k;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == USB_CTRL_ADDR && regWdata[CTRL_WAKEUP_BIT] |=> forceK;
   endproperty
   a_wakeup_k: assert property (p_wakeup_k) else $error("Wakeup did not force K");

   property p_visible;
      @(posedge clk) disable iff (!rst_n)
         regWrite && regAddr == USB_CTRL_ADDR && regWdata[CTRL_VISIBLE_BIT] |=> fifoVisible;
   endproperty
   a_visible: assert property (p_visible) else $error("FIFO not made visible");

   property p_out_sticky;
      @(posedge clk) disable iff (!rst_n)
         outFlags[2] && !(regWrite && regAddr == OUT_FLAGS_ADDR && !regWdata[2]) |=> outFlags[2];
   endproperty
   a_out_sticky: assert property (p_out_sticky) else $error("OUT flag lost without clear");

   property p_ctrl_reserved;
      @(posedge clk) disable iff (!rst_n)
         regRead && regAddr == USB_CTRL_ADDR |=> regRdata[7:3] == 5'h00;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("Control reserved bits set");

   property p_nak_needs_token;
      @(posedge clk) disable iff (!rst_n)
         sendNak |-> inToken && engineEnable;
   endproperty
   a_nak_needs_token: assert property (p_nak_needs_token) else $error("NAK without token");

   property p_flags_reset;
      @(posedge clk) $past(!rst_n) |-> inNakFlags == EP_NONE && outFlags == EP_NONE;
   endproperty
   a_flags_reset: assert property (p_flags_reset) else $error("Flags not cleared by reset");

   property p_token_range;
      @(posedge clk) disable iff (!rst_n)
         inToken && tokenEp > 3'd4 |-> !sendNak;
   endproperty
   a_token_range: assert property (p_token_range) else $error("NAK to unknown endpoint");

   property p_even_nak_ep0;
      @(posedge clk) disable iff (!rst_n)
         fifoPaired && !inNakFlags[0] |=> !inNakFlags[0];
   endproperty
   a_even_nak_ep0: assert property (p_even_nak_ep0) else $error("Even NAK flag set while paired");

   property p_nak_raises_status;
      @(posedge clk) disable iff (!rst_n)
         |(nakEvent & allowMask) |=> irqStatus[IRQ_NAK_BIT];
   endproperty
   a_nak_raises_status: assert property (p_nak_raises_status) else $error("NAK status not raised");
endmodule : usb_fifo_flag_status
`default_nettype wire

// file: usb_host_model.sv
// Purpose: Host side of the USB port: IN tokens and OUT FIFO fill level
// Assumes: One clock; changes driven just after the rising edge
// Notes:   Token endpoint shows its inverse while no token is sent
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   input  wire logic              clk,
   input  wire logic              sendNak,
   output logic                   inToken,
   output logic [2:0]             tokenEp,
   output usb_flag_pkg::ep_vec_t  outFifoFull
);
   import usb_flag_pkg::*;
   // ----------------------------------------
   // Token and fill control
   // ----------------------------------------
   initial begin
      inToken     = 1'b0;
      tokenEp     = 3'h7;
      outFifoFull = EP_NONE;
   end
   task automatic sendIn(input logic [2:0] ep, output logic nak);
      @(posedge clk);
      inToken <= 1'b1;
      tokenEp <= ep;
      #1 nak = sendNak;
      @(posedge clk);
      inToken <= 1'b0;
      tokenEp <= ~ep;
   endtask
   task automatic setFull(input ep_vec_t v);
      @(posedge clk);
      outFifoFull <= v;
   endtask
endmodule // usb_host_model
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the USB FIFO flag and status logic
// Assumes: 40 MHz clock, synchronous active-low reset
// Notes:   Firmware accesses are made by the bench tasks
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import usb_flag_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regRdata;
   logic        fifoPaired = 1'b0;
   logic        inToken;
   logic [2:0]  tokenEp;
   logic        sendNak;
   ep_vec_t     inLoadStrobe = EP_NONE;
   ep_vec_t     sizeWrite = EP_NONE;
   ep_vec_t     inSentDone = EP_NONE;
   ep_vec_t     outFifoFull;
   logic        engineEnable;
   logic        fifoVisible;
   logic        forceK;
   logic        irq;
   logic        irqA;
   int          failures = 0;
   int          numChecks = 0;
   always #12.5 clk = ~clk;
   usb_fifo_flag_status i_usb_fifo_flag_status (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .fifoPaired(fifoPaired), .inToken(inToken), .tokenEp(tokenEp), .sendNak(sendNak),
      .inLoadStrobe(inLoadStrobe), .sizeWrite(sizeWrite), .inSentDone(inSentDone),
      .outFifoFull(outFifoFull), .engineEnable(engineEnable), .fifoVisible(fifoVisible),
      .forceK(forceK), .irq(irq));
   usb_host_model i_usb_host_model (.clk(clk), .sendNak(sendNak), .inToken(inToken),
      .tokenEp(tokenEp), .outFifoFull(outFifoFull));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 check(regRdata, exp);
   endtask
   task automatic tok(input logic [2:0] ep, input logic exp);
      logic nak;
      i_usb_host_model.sendIn(ep, nak);
      check({7'h00, nak}, {7'h00, exp});
   endtask
   task automatic fifoEv(input ep_vec_t s, input ep_vec_t l, input ep_vec_t d);
      @(posedge clk);
      sizeWrite    <= s;
      inLoadStrobe <= l;
      inSentDone   <= d;
      @(posedge clk);
      sizeWrite    <= EP_NONE;
      inLoadStrobe <= EP_NONE;
      inSentDone   <= EP_NONE;
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d failures=%0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic testReset;
      rdChk(IN_NAK_FLAGS_ADDR, REG_RESET);
      rdChk(USB_CTRL_ADDR, REG_RESET);
      check({7'h00, irq}, 8'h00);
      tok(3'h1, 1'b0);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h00);
   endtask
   task automatic testCtrl;
      wr(USB_CTRL_ADDR, 8'hFF);
      rdChk(USB_CTRL_ADDR, 8'h07);
      check({5'h00, engineEnable, fifoVisible, forceK}, 8'h07);
      wr(USB_CTRL_ADDR, 8'h04);
      #1 check({5'h00, engineEnable, fifoVisible, forceK}, 8'h04);
      wr(8'h50, 8'hFF);
      rdChk(8'h50, 8'h00);
   endtask
   task automatic testNak;
      for (int ep = 0; ep < NUM_EP; ep++) begin
         tok(ep[2:0], 1'b1);
      end
      rdChk(IN_NAK_FLAGS_ADDR, 8'h1F);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h1F);
      wr(IRQ_MASK_ADDR, 8'h00);
      #1 irqA = irq;
      check({7'h00, irqA}, 8'h00);
      wr(IRQ_MASK_ADDR, 8'h03);
      #1 check({7'h00, irq}, 8'h01);
      rdChk(IRQ_STATUS_ADDR, 8'h01);
      rdChk(IRQ_STATUS_ADDR, 8'h00);
      wr(IN_NAK_FLAGS_ADDR, 8'h00);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h00);
   endtask
   task automatic testReady;
      fifoEv(5'h02, EP_NONE, EP_NONE);
      tok(3'h1, 1'b0);
      fifoEv(EP_NONE, EP_NONE, 5'h02);
      tok(3'h1, 1'b1);
      fifoEv(EP_NONE, 5'h04, EP_NONE);
      tok(3'h2, 1'b0);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h02);
      fifoEv(EP_NONE, EP_NONE, 5'h04);
      wr(IN_NAK_FLAGS_ADDR, 8'h00);
   endtask
   task automatic testClear;
      tok(3'h0, 1'b1);
      tok(3'h3, 1'b1);
      wr(IN_NAK_FLAGS_ADDR, 8'hF7);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h01);
      fork
         tok(3'h3, 1'b1);
         wr(IN_NAK_FLAGS_ADDR, 8'h00);
      join
      rdChk(IN_NAK_FLAGS_ADDR, 8'h08);
      wr(IN_NAK_FLAGS_ADDR, 8'h00);
   endtask
   task automatic testPaired;
      fifoPaired <= 1'b1;
      for (int ep = 0; ep < NUM_EP; ep++) begin
         tok(ep[2:0], 1'b1);
      end
      rdChk(IN_NAK_FLAGS_ADDR, {3'h0, ODD_EP_MASK});
      @(posedge clk);
      fifoPaired <= 1'b0;
      wr(IN_NAK_FLAGS_ADDR, 8'h00);
      i_usb_host_model.sendIn(3'h5, irqA);
      check({7'h00, irqA}, 8'h00);
      rdChk(IN_NAK_FLAGS_ADDR, 8'h00);
   endtask
   task automatic testOut;
      rdChk(IRQ_STATUS_ADDR, 8'h01);
      i_usb_host_model.setFull(5'h04);
      rdChk(OUT_FLAGS_ADDR, 8'h04);
      wr(OUT_FLAGS_ADDR, 8'h00);
      rdChk(OUT_FLAGS_ADDR, 8'h00);
      i_usb_host_model.setFull(5'h05);
      rdChk(OUT_FLAGS_ADDR, 8'h01);
      rdChk(IRQ_STATUS_ADDR, 8'h02);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      testReset();
      testCtrl();
      testNak();
      testReady();
      testClear();
      testPaired();
      testOut();
      tally_and_finish();
   end
   initial begin
      #(25 * 4000);
      failures++;
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
